// >>> common/zcd_pkg.sv
// Purpose: Shared constants for the zero-cross detector logic
// Assumes: 8-bit control register, plain register port
// Notes: Offsets are byte-free indices on the plain port
package zcd_pkg;
    // Register addresses
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_FLAG = 2'h1;
    localparam logic [1:0] ADDR_IRQEN = 2'h2;
    // Control register field positions
    localparam int BIT_EN = 7;
    localparam int BIT_OUT = 5;
    localparam int BIT_INV = 4;
    localparam int BIT_RISE = 1;
    localparam int BIT_FALL = 0;
    // Flag register field position
    localparam int BIT_FLAG = 0;
    // Reset values
    localparam logic RST_INV = 1'h0;
    localparam logic RST_RISE = 1'h0;
    localparam logic RST_FALL = 1'h0;
    localparam logic RST_FLAG = 1'h0;
    localparam logic RST_IRQEN = 1'h0;
    localparam logic RST_SYNC = 1'h0;
    // Synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage : zcd_pkg

// >>> design/zcd_sync.sv
// Purpose: Two-flop synchroniser for the analog detector level
// Assumes: Input is asynchronous to sys_clk
// Notes: Only the last stage is read outside
`timescale 1ns/1ps
`default_nettype none
module zcd_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    logic meta_r;
    logic stable_r;
    ////////////////////////////////////////////////////////////////////////////////
    // First stage feeds only the second; metastability settles here
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= zcd_pkg::RST_SYNC;
            stable_r <= zcd_pkg::RST_SYNC;
        end else begin
            meta_r <= asyncIn;
            stable_r <= meta_r;
        end
    end
    assign syncOut = stable_r;
endmodule : zcd_sync
`default_nettype wire

// >>> design/zcd_edge.sv
// Purpose: Rise and fall detector on a synchronous level
// Assumes: Level is already in the sys_clk domain
// Notes: Pulses are one cycle, combinational from previous-sample flop
`timescale 1ns/1ps
`default_nettype none
module zcd_edge (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Level in
    input wire logic level,
    // Edge pulses
    output logic rise,
    output logic fall
);
    logic prev_r;
    logic primed_r;
    ////////////////////////////////////////////////////////////////////////////////
    // Previous sample; first cycle after reset only primes, so no false edge
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r <= 1'h0;
            primed_r <= 1'h0;
        end else begin
            prev_r <= level;
            primed_r <= 1'h1;
        end
    end
    assign rise = primed_r & level & ~prev_r;
    assign fall = primed_r & ~level & prev_r;
endmodule : zcd_edge
`default_nettype wire

// >>> design/zcd_top.sv
// Purpose: Digital side of the zero-cross detector
// Assumes: Detector level is asynchronous; register port on sys_clk
// Notes: Contract
// Contract
// - Analog stage sinks above reference, sources below; that state feeds logic.
// - Non-inverted status bit is 1 while sinking, 0 while sourcing.
// - Invert bit set flips status: 1 means sourcing.
// - Inversion acts even when module enable is clear.
// - Rise and fall detectors watch the polarity-adjusted output.
// - Flag sets when an edge fires with its own enable set.
// - Rise enable qualifies rising edges, fall enable falling; both allowed.
// - Writing the invert bit may toggle output and set the flag.
// - Flag is cleared only by a software write.
// - Qualified edge in the clear cycle wins; flag stays 1.
// - Control bits: enable 7, status 5, invert 4, rise 1, fall 0.
// - Enabled: pin driven by analog stage; disabled: normal pin controls.
// - Enable reset value comes from the default-off configuration bit; the code resets it to 0 and loads the inverted strap on the first clock after release.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module zcd_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Configuration strap
    input wire logic crossingDefaultOffCfg,
    // Analog front end
    input wire logic detectorSinking,
    output logic analogEnable,
    // Pin steering
    output logic pinForcedAnalog,
    // Register port
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Event outputs
    output logic crossingIrqFlag,
    output logic crossingIrqReq,
    output logic crossingOut
);
    logic enable_r;
    logic strapped_r;
    logic outputInvert_r;
    logic riseEventEnable_r;
    logic fallEventEnable_r;
    logic crossingIrqEnable_r;
    logic flag_r;
    logic flag_nxt;
    logic sinkSync;
    logic statusBit;
    logic riseEv;
    logic fallEv;
    logic setEv;
    logic clearFlag;
    logic ctrlWrite;
    logic flagWrite;
    logic irqenWrite;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronise the raw sink/source state
    zcd_sync u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn(detectorSinking),
        .syncOut(sinkSync)
    );

    // Inversion is outside the enable so it always acts
    assign statusBit = sinkSync ^ outputInvert_r;
    // Unregistered route to neighbouring peripherals
    assign crossingOut = statusBit;

    zcd_edge u_edge (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level(statusBit),
        .rise(riseEv),
        .fall(fallEv)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Qualified edges; an invert write toggles statusBit and so lands here too
    assign setEv = (riseEv & riseEventEnable_r) | (fallEv & fallEventEnable_r);

    // One decode for every register write, so the three stay in step
    function automatic logic hitWrite(
        input logic wr,
        input logic [1:0] addr,
        input logic [1:0] target
    );
        return wr && addr == target;
    endfunction : hitWrite

    assign ctrlWrite = hitWrite(regWr, regAddr, zcd_pkg::ADDR_CTRL);
    assign flagWrite = hitWrite(regWr, regAddr, zcd_pkg::ADDR_FLAG);
    assign irqenWrite = hitWrite(regWr, regAddr, zcd_pkg::ADDR_IRQEN);
    // Writing 0 clears; writing 1 leaves the flag alone
    assign clearFlag = flagWrite && !regWdata[zcd_pkg::BIT_FLAG];

    // Set beats clear; nothing else clears the flag
    always_comb begin
        flag_nxt = flag_r;
        if (clearFlag) begin
            flag_nxt = 1'h0;
        end
        if (setEv) begin
            flag_nxt = 1'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_r <= zcd_pkg::RST_FLAG;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable: strap captured on the first clock after release, not in reset
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_r <= 1'h0;
            strapped_r <= 1'h0;
        end else if (!strapped_r) begin
            strapped_r <= 1'h1;
            enable_r <= ~crossingDefaultOffCfg;
        end else if (ctrlWrite) begin
            enable_r <= regWdata[zcd_pkg::BIT_EN];
        end
    end

    // Control bits other than enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            outputInvert_r <= zcd_pkg::RST_INV;
            riseEventEnable_r <= zcd_pkg::RST_RISE;
            fallEventEnable_r <= zcd_pkg::RST_FALL;
        end else if (ctrlWrite) begin
            outputInvert_r <= regWdata[zcd_pkg::BIT_INV];
            riseEventEnable_r <= regWdata[zcd_pkg::BIT_RISE];
            fallEventEnable_r <= regWdata[zcd_pkg::BIT_FALL];
        end
    end

    // Local interrupt enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            crossingIrqEnable_r <= zcd_pkg::RST_IRQEN;
        end else if (irqenWrite) begin
            crossingIrqEnable_r <= regWdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; unused bits and unmapped addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        case (regAddr)
            zcd_pkg::ADDR_CTRL: begin
                rdata_nxt[zcd_pkg::BIT_EN] = enable_r;
                rdata_nxt[zcd_pkg::BIT_OUT] = statusBit;
                rdata_nxt[zcd_pkg::BIT_INV] = outputInvert_r;
                rdata_nxt[zcd_pkg::BIT_RISE] = riseEventEnable_r;
                rdata_nxt[zcd_pkg::BIT_FALL] = fallEventEnable_r;
            end
            zcd_pkg::ADDR_FLAG: begin
                rdata_nxt[zcd_pkg::BIT_FLAG] = flag_r;
            end
            zcd_pkg::ADDR_IRQEN: begin
                rdata_nxt[0] = crossingIrqEnable_r;
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    // Read data valid the cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= regRd ? rdata_nxt : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs; outer gates live in the interrupt controller
    assign regRdata = rdata_r;
    assign crossingIrqFlag = flag_r;
    assign crossingIrqReq = flag_r & crossingIrqEnable_r;
    assign analogEnable = enable_r;
    assign pinForcedAnalog = enable_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_setwins;
        @(posedge sys_clk) disable iff (sys_rst) setEv |=> flag_r;
    endproperty
    a_setwins: assert property (p_setwins) else $error("flag lost on edge");

    property p_noselfclear;
        @(posedge sys_clk) disable iff (sys_rst) flag_r && !clearFlag |=> flag_r;
    endproperty
    a_noselfclear: assert property (p_noselfclear) else $error("flag self cleared");

    property p_rise;
        @(posedge sys_clk) disable iff (sys_rst)
            $rose(statusBit) && riseEventEnable_r && $past(strapped_r) |=> flag_r;
    endproperty
    a_rise: assert property (p_rise) else $error("rise not flagged");

    property p_fall;
        @(posedge sys_clk) disable iff (sys_rst)
            $fell(statusBit) && fallEventEnable_r && $past(strapped_r) |=> flag_r;
    endproperty
    a_fall: assert property (p_fall) else $error("fall not flagged");

    property p_noset;
        @(posedge sys_clk) disable iff (sys_rst)
            !flag_r && !riseEventEnable_r && !fallEventEnable_r |=> !flag_r;
    endproperty
    a_noset: assert property (p_noset) else $error("flag set without enable");

    property p_polarity;
        @(posedge sys_clk) disable iff (sys_rst)
            !enable_r && $changed(outputInvert_r) && $stable(sinkSync) |-> $changed(statusBit);
    endproperty
    a_polarity: assert property (p_polarity) else $error("invert ignored while off");

    property p_sync;
        @(posedge sys_clk) disable iff (sys_rst)
            !outputInvert_r && $stable(outputInvert_r) && $changed(statusBit)
            |-> $past(detectorSinking, 2) == statusBit;
    endproperty
    a_sync: assert property (p_sync) else $error("sync depth wrong");

    property p_read;
        @(posedge sys_clk) disable iff (sys_rst)
            regRd && regAddr == zcd_pkg::ADDR_FLAG |=> regRdata[0] == $past(flag_r);
    endproperty
    a_read: assert property (p_read) else $error("flag read wrong");

    property p_pin;
        @(posedge sys_clk) disable iff (sys_rst)
            ctrlWrite && strapped_r |=> pinForcedAnalog == $past(regWdata[zcd_pkg::BIT_EN]);
    endproperty
    a_pin: assert property (p_pin) else $error("pin steering");

    property p_invflag;
        @(posedge sys_clk) disable iff (sys_rst)
            $changed(outputInvert_r) && $stable(sinkSync) && $past(strapped_r)
            && (statusBit ? riseEventEnable_r : fallEventEnable_r) |=> flag_r;
    endproperty
    a_invflag: assert property (p_invflag) else $error("invert write did not flag");

    property p_both;
        @(posedge sys_clk) disable iff (sys_rst)
            $changed(statusBit) && riseEventEnable_r && fallEventEnable_r && $past(strapped_r)
            |=> flag_r;
    endproperty
    a_both: assert property (p_both) else $error("edge missed with both enables");

    property p_clear;
        @(posedge sys_clk) disable iff (sys_rst) clearFlag && !setEv |=> !flag_r;
    endproperty
    a_clear: assert property (p_clear) else $error("flag clear ignored");

    property p_strap;
        @(posedge sys_clk) disable iff (sys_rst)
            $rose(strapped_r) |-> enable_r == !$past(crossingDefaultOffCfg);
    endproperty
    a_strap: assert property (p_strap) else $error("enable not loaded from strap");

    property p_ctrlkeep;
        @(posedge sys_clk) disable iff (sys_rst)
            !ctrlWrite |=> $stable(outputInvert_r) && $stable(riseEventEnable_r)
            && $stable(fallEventEnable_r);
    endproperty
    a_ctrlkeep: assert property (p_ctrlkeep) else $error("control bits moved");

    property p_first;
        @(posedge sys_clk) disable iff (sys_rst) !$past(strapped_r) |-> !setEv;
    endproperty
    a_first: assert property (p_first) else $error("edge event right after reset");

    property p_ctrlrd;
        @(posedge sys_clk) disable iff (sys_rst)
            regRd && regAddr == zcd_pkg::ADDR_CTRL
            |=> regRdata[zcd_pkg::BIT_OUT] == $past(statusBit);
    endproperty
    a_ctrlrd: assert property (p_ctrlrd) else $error("status bit read wrong");

    property p_rdidle;
        @(posedge sys_clk) disable iff (sys_rst) !regRd |=> regRdata == 8'h00;
    endproperty
    a_rdidle: assert property (p_rdidle) else $error("read data outside its cycle");

    property p_irqenrd;
        @(posedge sys_clk) disable iff (sys_rst)
            regRd && regAddr == zcd_pkg::ADDR_IRQEN
            |=> regRdata == {7'h00, $past(crossingIrqEnable_r)};
    endproperty
    a_irqenrd: assert property (p_irqenrd) else $error("irq enable read wrong");

    property p_unmapped;
        @(posedge sys_clk) disable iff (sys_rst)
            regRd && regAddr == 2'h3 |=> regRdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : zcd_top
`default_nettype wire

// >>> sim/zcd_ac_source.sv
// Purpose: AC source behind a series resistor, seen as sink/source state
// Assumes: Bench sets the wanted side of the reference
// Notes: Output moves off the clock grid, like the analog stage
`timescale 1ns/1ps
`default_nettype none
module zcd_ac_source #(
    parameter real SETTLE_NS = 2.3
) (
    // Source level
    input wire logic aboveRef,
    // Raw detector state
    output logic detectorSinking
);
    // Sink while above reference; the settle delay keeps it asynchronous
    initial detectorSinking = 1'b0;
    always @(aboveRef) begin
        detectorSinking <= #(SETTLE_NS) aboveRef;
    end
endmodule : zcd_ac_source
`default_nettype wire

// >>> sim/zcd_top_tb.sv
// Purpose: Self-checking bench for the zero-cross detector logic
// Assumes: Strap low at the first reset, high for a second reset in mid-run
// Notes: Each scenario is one task; waits are fixed cycle counts
`timescale 1ns/1ps
`default_nettype none
module zcd_top_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic aboveRef = 1'b0;
    logic strapCfg = 1'b0;
    logic detectorSinking;
    logic analogEnable, pinForcedAnalog, crossingIrqFlag, crossingIrqReq, crossingOut;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic [7:0] rv;
    int err_count = 0;
    int checks = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, far side and device
    always #2.5 sys_clk = ~sys_clk;
    zcd_ac_source i_src (.aboveRef(aboveRef), .detectorSinking(detectorSinking));
    zcd_top i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .crossingDefaultOffCfg(strapCfg),
        .detectorSinking(detectorSinking), .analogEnable(analogEnable),
        .pinForcedAnalog(pinForcedAnalog), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .crossingIrqFlag(crossingIrqFlag),
        .crossingIrqReq(crossingIrqReq), .crossingOut(crossingOut));
    ////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk
    // One idle edge before each access keeps strobes from colliding
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task automatic level(input logic v);
        @(posedge sys_clk);
        aboveRef <= v;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask : level
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset;
        rd(zcd_pkg::ADDR_CTRL, rv);
        chk("ctrl after reset", 8'h80, rv);
        chk("pin forced", 8'h01, {7'h00, pinForcedAnalog});
        rd(2'h3, rv);
        chk("unmapped read", 8'h00, rv);
        $display("test reset done");
    endtask : t_reset
    task automatic t_polarity;
        wr(zcd_pkg::ADDR_CTRL, 8'h00);
        level(1'b1);
        rd(zcd_pkg::ADDR_CTRL, rv);
        chk("status sinking", 8'h20, rv);
        chk("pin released", 8'h00, {6'h00, analogEnable, pinForcedAnalog});
        // Reserved and status bits written high must not stick
        wr(zcd_pkg::ADDR_CTRL, 8'h7C);
        rd(zcd_pkg::ADDR_CTRL, rv);
        chk("status inverted", 8'h10, rv);
        chk("zero-cross out", 8'h00, {7'h00, crossingOut});
        wr(2'h3, 8'hFF);
        rd(zcd_pkg::ADDR_CTRL, rv);
        chk("ctrl kept", 8'h10, rv);
        $display("test polarity done");
    endtask : t_polarity
    task automatic t_edges;
        logic [7:0] ctl [8] = '{8'h82, 8'h82, 8'h81, 8'h81, 8'h83, 8'h83, 8'h80, 8'h80};
        logic lv [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        logic ex [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        wr(zcd_pkg::ADDR_CTRL, 8'h10);
        level(1'b0);
        wr(zcd_pkg::ADDR_CTRL, 8'h80);
        wr(zcd_pkg::ADDR_IRQEN, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(zcd_pkg::ADDR_CTRL, ctl[i]);
            wr(zcd_pkg::ADDR_FLAG, 8'h00);
            level(lv[i]);
            chk("edge flag", {7'h00, ex[i]}, {7'h00, crossingIrqFlag});
            chk("irq request", {7'h00, ex[i]}, {7'h00, crossingIrqReq});
        end
        wr(zcd_pkg::ADDR_CTRL, 8'h83);
        level(1'b1);
        repeat (20) @(posedge sys_clk);
        // Writing a one to the flag must not clear it
        wr(zcd_pkg::ADDR_FLAG, 8'h01);
        rd(zcd_pkg::ADDR_FLAG, rv);
        chk("flag sticky", 8'h01, rv);
        rd(zcd_pkg::ADDR_IRQEN, rv);
        chk("irq enable readback", 8'h01, rv);
        wr(zcd_pkg::ADDR_IRQEN, 8'h00);
        #1 chk("irq gated off", 8'h00, {7'h00, crossingIrqReq});
        $display("test edges done");
    endtask : t_edges
    task automatic t_inv_write;
        wr(zcd_pkg::ADDR_CTRL, 8'h02);
        level(1'b0);
        wr(zcd_pkg::ADDR_FLAG, 8'h00);
        wr(zcd_pkg::ADDR_CTRL, 8'h12);
        repeat (3) @(posedge sys_clk);
        #1 chk("flag from invert", 8'h01, {7'h00, crossingIrqFlag});
        wr(zcd_pkg::ADDR_FLAG, 8'h00);
        #1 chk("flag cleared", 8'h00, {7'h00, crossingIrqFlag});
        // Invert drop falls on one edge, the clear lands on the next
        @(posedge sys_clk);
        regAddr <= zcd_pkg::ADDR_CTRL;
        regWdata <= 8'h01;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regAddr <= zcd_pkg::ADDR_FLAG;
        regWdata <= 8'h00;
        @(posedge sys_clk);
        regWr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk("set beats clear", 8'h01, {7'h00, crossingIrqFlag});
        $display("test invert write done");
    endtask : t_inv_write
    // Second reset with the strap high: module must come up off
    task automatic t_strap;
        @(posedge sys_clk);
        strapCfg <= 1'b1;
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(zcd_pkg::ADDR_CTRL, rv);
        chk("ctrl strapped off", 8'h00, rv);
        chk("pin after strap", 8'h00, {7'h00, pinForcedAnalog});
        rd(zcd_pkg::ADDR_FLAG, rv);
        chk("flag after reset", 8'h00, rv);
        wr(zcd_pkg::ADDR_CTRL, 8'h80);
        #1 chk("pin forced by write", 8'h01, {7'h00, pinForcedAnalog});
        $display("test strap done");
    endtask : t_strap
    ////////////////////////////////////////////////////////////////////////
    // Main sequence and hang guard
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_polarity();
        t_edges();
        t_inv_write();
        t_strap();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        give_verdict();
    end
endmodule : zcd_top_tb
`default_nettype wire
